// ===== disk_host_map.vh
// register offsets, field positions and timing counts of the flexible disk host controller
`ifndef DISK_HOST_MAP_VH
`define DISK_HOST_MAP_VH

// register byte offsets on the apb bus
`define CTRL_OFF      12'h000
`define CMD_OFF       12'h004
`define STAT_OFF      12'h008
`define IRQ_STAT_OFF  12'h00c
`define IRQ_MASK_OFF  12'h010
`define RCNT_OFF      12'h014

// control register fields
`define CTRL_SEL      0
`define CTRL_MOTOR    1
`define CTRL_HEAD     2
`define CTRL_WEN      3
`define CTRL_CODE_LO  4
`define CTRL_CODE_HI  5
`define CTRL_W        6
`define CTRL_RESET    6'h00

// command register fields, write only
`define CMD_STEP      0
`define CMD_DIR       1
`define CMD_WBIT      2

// status register fields
`define ST_PRESENT    0
`define ST_CHANGED    1
`define ST_DENSITY    2
`define ST_PROTECT    3
`define ST_TRACK0     4
`define ST_INDEX      5
`define ST_BUSY       6
`define ST_GATE       7
`define ST_TRACK_LSB  8

// interrupt event bits
`define EV_INDEX      0
`define EV_READ       1
`define EV_CHANGED    2
`define EV_DONE       3
`define EV_REFUSED    4
`define EV_W          5

// timing
`define CLK_NS        20
`define DIR_SETUP_NS  1000
`define STEP_LOW_NS   1000
`define WPULSE_NS     200
`define DIR_SETUP_CYC ((`DIR_SETUP_NS + `CLK_NS - 1) / `CLK_NS)
`define STEP_LOW_CYC  ((`STEP_LOW_NS + `CLK_NS - 1) / `CLK_NS)
`define WPULSE_CYC    ((`WPULSE_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// ===== pin_sync.v
// two flip-flop synchroniser for a group of drive status pins
`timescale 1ns/1ps
module pin_sync #(
    parameter                 WIDTH = 7,
    parameter [WIDTH-1:0]     IDLE  = {WIDTH{1'b1}}
) (
    input  wire               pclk,
    input  wire               presetn,
    input  wire [WIDTH-1:0]   pins,
    output wire [WIDTH-1:0]   pins_s
);
    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    // pins idle high, so reset to the idle level to avoid false edges
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= IDLE;
            sync_q <= IDLE;
        end else begin
            meta_q <= pins;
            sync_q <= meta_q;
        end
    end

    assign pins_s = sync_q;
endmodule

// ===== disk_host.v
// flexible disk drive host controller with apb registers
//
// Contract
// - seek sense high moves head away from spindle, low toward it.
// - head choice low picks lower head, high picks upper head.
// - spindle enable low runs the motor.
// - drive enabled only with unit select low and both select codes low.
// - each low write pulse records one bit while write gate is low.
// - host holds write gate low only while it wants data recorded.
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/1ps
`include "disk_host_map.vh"
module disk_host (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg         irq,
    output reg         unit_select_n,
    output reg         select_code_low,
    output reg         select_code_high,
    output reg         spindle_enable_n,
    output reg         head_choice,
    output reg         seek_sense,
    output reg         head_move_strobe_n,
    output reg         write_enable_gate,
    output reg         serial_write_n,
    input  wire        media_present_n,
    input  wire        media_changed_n,
    input  wire        density_indicator_n,
    input  wire        revolution_marker_n,
    input  wire        serial_read_n,
    input  wire        outermost_track_n,
    input  wire        write_protect_n
);
    localparam [1:0] S_IDLE = 2'd0;
    localparam [1:0] S_DSET = 2'd1;
    localparam [1:0] S_STEP = 2'd2;
    localparam [1:0] S_WBIT = 2'd3;

    // counts are reckoned in 32-bit arithmetic, then cut on purpose to the counter width
    localparam integer DSET_INT = `DIR_SETUP_CYC;
    localparam integer STEP_INT = `STEP_LOW_CYC;
    localparam integer WBIT_INT = `WPULSE_CYC;
    localparam [7:0]   DSET_CYC = DSET_INT[7:0];
    localparam [7:0]   STEP_CYC = STEP_INT[7:0];
    localparam [7:0]   WBIT_CYC = WBIT_INT[7:0];

    // true when the apb address selects the given register
    function hit;
        input [11:0] addr;
        input [11:0] off;
        begin
            hit = (addr == off);
        end
    endfunction

    wire [6:0] pins_s;
    wire       present_s;
    wire       changed_s;
    wire       density_s;
    wire       index_s;
    wire       read_s;
    wire       track0_s;
    wire       protect_s;

    // every drive output is asynchronous to pclk
    pin_sync #(
        .WIDTH (7),
        .IDLE  (7'h7f)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pins    ({write_protect_n, outermost_track_n, serial_read_n, revolution_marker_n,
                   density_indicator_n, media_changed_n, media_present_n}),
        .pins_s  (pins_s)
    );

    assign present_s = ~pins_s[0];
    assign changed_s = ~pins_s[1];
    assign density_s = ~pins_s[2];
    assign index_s   = ~pins_s[3];
    assign read_s    = ~pins_s[4];
    assign track0_s  = ~pins_s[5];
    assign protect_s = ~pins_s[6];

    reg [`CTRL_W-1:0] ctrl_q;
    reg [`EV_W-1:0]   ist_q;
    reg [`EV_W-1:0]   ist_d;
    reg [`EV_W-1:0]   imask_q;
    reg [15:0]        rcnt_q;
    reg [7:0]         track_q;
    reg [1:0]         state_q;
    reg [7:0]         cnt_q;
    reg               index_d1_q;
    reg               read_d1_q;
    reg               changed_d1_q;
    reg               step_dir_q;

    wire       wr_fire;
    wire       rd_go;
    wire       mapped;
    wire       busy;
    wire       gate_want;
    wire       gate_open;
    wire [4:0] ev;
    wire       wr_ctrl;
    wire       wr_cmd;
    wire       wr_istat;
    wire       wr_imask;
    wire       wr_rcnt;
    wire       drive_on;

    // the access completes on the edge where our registered pready is high
    assign wr_fire   = psel & penable & pready & pwrite;
    assign rd_go     = psel & penable & ~pready;
    assign mapped    = hit(paddr, `CTRL_OFF) | hit(paddr, `CMD_OFF) | hit(paddr, `STAT_OFF) |
                       hit(paddr, `IRQ_STAT_OFF) | hit(paddr, `IRQ_MASK_OFF) | hit(paddr, `RCNT_OFF);
    assign busy      = (state_q != S_IDLE);
    assign gate_want = ctrl_q[`CTRL_SEL] & ctrl_q[`CTRL_WEN];

    // write strobes per register, all on the single completing edge of the access
    assign wr_ctrl   = wr_fire & hit(paddr, `CTRL_OFF);
    assign wr_cmd    = wr_fire & hit(paddr, `CMD_OFF);
    assign wr_istat  = wr_fire & hit(paddr, `IRQ_STAT_OFF);
    assign wr_imask  = wr_fire & hit(paddr, `IRQ_MASK_OFF);
    assign wr_rcnt   = wr_fire & hit(paddr, `RCNT_OFF);
    // a step strobe sent to a drive that is not enabled would be lost, so none is sent; write pulses check only the open gate
    assign drive_on  = ctrl_q[`CTRL_SEL] & ~ctrl_q[`CTRL_CODE_LO] & ~ctrl_q[`CTRL_CODE_HI];
    assign gate_open = gate_want & ~protect_s;

    // falling edges of the pulse pins and the media change line
    assign ev[`EV_INDEX]   = index_s & ~index_d1_q;
    assign ev[`EV_READ]    = read_s & ~read_d1_q;
    assign ev[`EV_CHANGED] = changed_s & ~changed_d1_q;
    // done marks the last cycle of a step strobe or a write pulse
    assign ev[`EV_DONE]    = ((state_q == S_STEP) | (state_q == S_WBIT)) & (cnt_q == 8'h01);
    assign ev[`EV_REFUSED] = gate_want & protect_s;

    // apb slave: one wait state, so prdata and pready come from flip-flops
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= rd_go;
            pslverr <= rd_go & ~mapped;
            prdata  <= 32'h00000000;
            if (rd_go & ~pwrite) begin
                if (hit(paddr, `CTRL_OFF))
                    prdata <= {26'h0000000, ctrl_q};
                else if (hit(paddr, `STAT_OFF))
                    prdata <= {16'h0000, track_q, gate_open, busy, index_s, track0_s,
                               protect_s, density_s, changed_s, present_s};
                else if (hit(paddr, `IRQ_STAT_OFF))
                    prdata <= {27'h0000000, ist_q};
                else if (hit(paddr, `IRQ_MASK_OFF))
                    prdata <= {27'h0000000, imask_q};
                else if (hit(paddr, `RCNT_OFF))
                    prdata <= {16'h0000, rcnt_q};
            end
        end
    end

    // control and mask registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q  <= `CTRL_RESET;
            imask_q <= 5'h00;
        end else begin
            if (wr_ctrl)
                ctrl_q <= pwdata[`CTRL_W-1:0];
            if (wr_imask)
                imask_q <= pwdata[`EV_W-1:0];
        end
    end

    // sticky status: an event in the clearing cycle survives the clear
    always @* begin
        ist_d = ist_q;
        if (wr_istat)
            ist_d = ist_d & ~pwdata[`EV_W-1:0];
        // or-ing the events in last lets a set win over a clear in the same cycle
        ist_d = ist_d | ev;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ist_q        <= 5'h00;
            irq          <= 1'b0;
            index_d1_q   <= 1'b0;
            read_d1_q    <= 1'b0;
            changed_d1_q <= 1'b0;
            rcnt_q       <= 16'h0000;
        end else begin
            ist_q        <= ist_d;
            irq          <= |(ist_d & imask_q);
            index_d1_q   <= index_s;
            read_d1_q    <= read_s;
            changed_d1_q <= changed_s;
            // read bit counter, cleared by any write to it
            if (wr_rcnt)
                rcnt_q <= 16'h0000;
            else if (ev[`EV_READ])
                rcnt_q <= rcnt_q + 16'h0001;
        end
    end

    // static drive lines follow the control register; the write gate also stays closed on a protected disk
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unit_select_n     <= 1'b1;
            select_code_low   <= 1'b1;
            select_code_high  <= 1'b1;
            spindle_enable_n  <= 1'b1;
            head_choice       <= 1'b0;
            write_enable_gate <= 1'b1;
        end else begin
            unit_select_n     <= ~ctrl_q[`CTRL_SEL];
            select_code_low   <= ctrl_q[`CTRL_CODE_LO];
            select_code_high  <= ctrl_q[`CTRL_CODE_HI];
            spindle_enable_n  <= ~ctrl_q[`CTRL_MOTOR];
            head_choice       <= ctrl_q[`CTRL_HEAD];
            write_enable_gate <= ~gate_open;
        end
    end

    // step and write pulse engine; commands while busy are dropped
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q            <= S_IDLE;
            cnt_q              <= 8'h00;
            seek_sense         <= 1'b0;
            step_dir_q         <= 1'b0;
            head_move_strobe_n <= 1'b1;
            serial_write_n     <= 1'b1;
            track_q            <= 8'h00;
        end else begin
            if (track0_s)
                track_q <= 8'h00;
            case (state_q)
                S_IDLE: begin
                    // a step to an enabled drive wins over a write bit in the same command word
                    if (wr_cmd) begin
                        if (pwdata[`CMD_STEP] & drive_on) begin
                            // direction settles before the strobe falls
                            seek_sense <= pwdata[`CMD_DIR];
                            step_dir_q <= pwdata[`CMD_DIR];
                            cnt_q      <= DSET_CYC;
                            state_q    <= S_DSET;
                        end else if (pwdata[`CMD_WBIT] & gate_open & ~write_enable_gate) begin
                            serial_write_n <= 1'b0;
                            cnt_q          <= WBIT_CYC;
                            state_q        <= S_WBIT;
                        end
                    end
                end
                S_DSET: begin
                    cnt_q <= cnt_q - 8'h01;
                    if (cnt_q == 8'h01) begin
                        head_move_strobe_n <= 1'b0;
                        cnt_q              <= STEP_CYC;
                        state_q            <= S_STEP;
                    end
                end
                S_STEP: begin
                    cnt_q <= cnt_q - 8'h01;
                    if (cnt_q == 8'h01) begin
                        head_move_strobe_n <= 1'b1;
                        state_q            <= S_IDLE;
                        // toward spindle counts up, away counts down to zero
                        if (!step_dir_q)
                            track_q <= track_q + 8'h01;
                        else if (track_q != 8'h00 && !track0_s)
                            track_q <= track_q - 8'h01;
                    end
                end
                S_WBIT: begin
                    cnt_q <= cnt_q - 8'h01;
                    if (cnt_q == 8'h01) begin
                        serial_write_n <= 1'b1;
                        state_q        <= S_IDLE;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end
endmodule

// ===== disk_host_checker.sv
// pin and timing checks for the flexible disk host controller
`timescale 1ns/1ps
module disk_host_checker (
    input logic        pclk,
    input logic        presetn,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic        pready,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic        unit_select_n,
    input logic        select_code_low,
    input logic        select_code_high,
    input logic        spindle_enable_n,
    input logic        head_choice,
    input logic        seek_sense,
    input logic        head_move_strobe_n,
    input logic        write_enable_gate,
    input logic        serial_write_n,
    input logic        write_protect_n
);
    logic [5:0] ctl_q;
    logic [3:0] prot_q;
    // shadow control word; protect history outlasts the pin synchroniser lag
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q  <= 6'h00;
            prot_q <= 4'hf; // the pin idles high, as the synchroniser assumes
        end else begin
            if (psel && penable && pready && pwrite && paddr == 12'h000)
                ctl_q <= pwdata[5:0];
            prot_q <= {prot_q[2:0], write_protect_n};
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    seek_hold_a: assert property (!head_move_strobe_n |-> $stable(seek_sense))
        else $error("seek sense moved under strobe");
    seek_setup_a: assert property ($fell(head_move_strobe_n) |-> $past(seek_sense, 40) == seek_sense)
        else $error("seek sense not set up");
    strobe_len_a: assert property ($fell(head_move_strobe_n) |-> ##49 !head_move_strobe_n ##1 head_move_strobe_n)
        else $error("strobe width wrong");
    strobe_sel_a: assert property (!head_move_strobe_n |->
        !unit_select_n && !select_code_low && !select_code_high)
        else $error("strobe on unselected drive");
    ctl_pins_a: assert property ($past(presetn) && $stable(ctl_q) |->
        {select_code_high, select_code_low, head_choice, spindle_enable_n, unit_select_n} ==
        {ctl_q[5:4], ctl_q[2], ~ctl_q[1:0]})
        else $error("control pins differ from control word");
    wdata_gate_a: assert property (!serial_write_n |-> !write_enable_gate)
        else $error("write pulse with gate closed");
    wpulse_a: assert property ($fell(serial_write_n) |-> ##9 !serial_write_n ##1 serial_write_n)
        else $error("write pulse width wrong");
    gate_prot_a: assert property (prot_q == 4'h0 |-> write_enable_gate)
        else $error("gate open on protected disk");
    gate_wen_a: assert property ($past(presetn) && $stable(ctl_q) && &prot_q |->
        write_enable_gate == !(ctl_q[0] && ctl_q[3]))
        else $error("gate differs from request");
endmodule

bind disk_host disk_host_checker u_disk_host_checker (.*);

// ===== disk_drive_model.sv
// behavioural flexible disk drive facing the host controller
`timescale 1ns/1ps
module disk_drive_model (
    input  logic pclk,
    input  logic disk_in,
    input  logic dense,
    input  logic locked,
    input  logic read_bit,
    input  logic unit_select_n,
    input  logic select_code_low,
    input  logic select_code_high,
    input  logic spindle_enable_n,
    input  logic head_choice,
    input  logic seek_sense,
    input  logic head_move_strobe_n,
    input  logic write_enable_gate,
    input  logic serial_write_n,
    output logic media_present_n,
    output logic media_changed_n,
    output logic density_indicator_n,
    output logic revolution_marker_n,
    output logic serial_read_n,
    output logic outermost_track_n,
    output logic write_protect_n,
    output int   track,
    output int   bits_lo,
    output int   bits_hi
);
    logic       en;
    logic [7:0] rev = 8'hff;
    assign en = !unit_select_n && !select_code_low && !select_code_high;
    assign media_present_n     = !disk_in;
    assign density_indicator_n = !(disk_in && dense);
    assign write_protect_n     = !(disk_in && locked);
    assign outermost_track_n   = track != 0;
    assign serial_read_n       = !(read_bit && disk_in);
    assign revolution_marker_n = rev > 8'h03;
    // spindle turns only while the motor line is low; short index mark per turn
    always @(posedge pclk) rev <= spindle_enable_n ? 8'hff : rev + 8'h01;
    initial begin
        track = 1;
        bits_lo = 0;
        bits_hi = 0;
        media_changed_n = 1'b1;
    end
    // head moves on the falling strobe edge, only while enabled
    always @(negedge head_move_strobe_n) if (en) begin
        track = seek_sense ? (track > 0 ? track - 1 : 0) : track + 1;
        if (disk_in) media_changed_n = 1'b1;
    end
    always @(negedge disk_in) media_changed_n = 1'b0;
    always @(negedge serial_write_n) if (en && !write_enable_gate) begin
        if (head_choice)
            bits_hi++;
        else
            bits_lo++;
    end
endmodule

// ===== disk_host_tb.sv
// self-checking testbench for the flexible disk host controller
`timescale 1ns/1ps
`include "disk_host_map.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); end end
module disk_host_tb;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        disk_in = 1, dense = 1, locked = 0, read_bit = 0, err;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic        pready, pslverr, irq, unit_select_n, select_code_low, select_code_high, spindle_enable_n;
    logic        head_choice, seek_sense, head_move_strobe_n, write_enable_gate, serial_write_n;
    logic        media_present_n, media_changed_n, density_indicator_n, revolution_marker_n;
    logic        serial_read_n, outermost_track_n, write_protect_n;
    logic [3:0]  dirs = 4'b1001;
    int          exp_t [4] = '{0, 1, 2, 1};
    int          track, bits_lo, bits_hi, n_mismatch = 0, tests_run = 0;
    disk_host u_disk_host (.*);
    disk_drive_model u_disk_drive_model (.*);
    always #10 pclk = ~pclk;
    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask
    // command then poll busy; the engine drops commands while busy
    task automatic cmd(input logic [31:0] d);
        apb(1'b1, `CMD_OFF, d);
        do apb(1'b0, `STAT_OFF, 32'h0); while (rd[`ST_BUSY] !== 1'b0);
    endtask
    task automatic close_out();
        if (n_mismatch == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rdc(`CTRL_OFF, 32'h0);
        `CHK(unit_select_n, 1'b1)
        apb(1'b0, 12'h0ff, 32'h0);
        `CHK({err, rd}, 33'h100000000)
        apb(1'b1, `CTRL_OFF, 32'h07);
        rdc(`CTRL_OFF, 32'h07);
        `CHK({select_code_high, select_code_low, head_choice, spindle_enable_n, unit_select_n}, 5'h04)
        apb(1'b1, `IRQ_MASK_OFF, 32'h08);
        // walk onto track 0 and back out
        for (int i = 0; i < 4; i++) begin
            cmd({30'h0, dirs[i], 1'b1});
            `CHK(seek_sense, dirs[i])
            `CHK(track, exp_t[i])
            `CHK(rd[15:8], exp_t[i][7:0])
        end
        `CHK(rd[4:0], 5'h05)
        `CHK(irq, 1'b1)
        apb(1'b1, `IRQ_MASK_OFF, 32'h0);
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b0)
        apb(1'b1, `IRQ_STAT_OFF, 32'h08);
        apb(1'b1, `IRQ_MASK_OFF, 32'h08);
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b0)
        apb(1'b1, `CMD_OFF, 32'h1);
        cmd(32'h1);
        `CHK(track, 2)
        apb(1'b1, `CTRL_OFF, 32'h06);
        apb(1'b1, `CMD_OFF, 32'h1);
        repeat (120) @(posedge pclk);
        `CHK(track, 2)
        apb(1'b1, `CTRL_OFF, 32'h0d);
        repeat (3) cmd(32'h4);
        `CHK(write_enable_gate, 1'b0)
        `CHK(bits_hi, 3)
        apb(1'b1, `CTRL_OFF, 32'h09);
        cmd(32'h4);
        `CHK(bits_lo, 1)
        locked <= 1'b1;
        repeat (4) @(posedge pclk);
        cmd(32'h4);
        `CHK(write_enable_gate, 1'b1)
        `CHK(bits_lo, 1)
        apb(1'b0, `IRQ_STAT_OFF, 32'h0);
        `CHK(rd[`EV_REFUSED], 1'b1)
        `CHK(rd[`EV_INDEX], 1'b1)
        locked <= 1'b0;
        apb(1'b1, `RCNT_OFF, 32'h0);
        repeat (5) begin
            read_bit <= 1'b1;
            repeat (3) @(posedge pclk);
            read_bit <= 1'b0;
            repeat (3) @(posedge pclk);
        end
        repeat (3) @(posedge pclk);
        rdc(`RCNT_OFF, 32'h5);
        apb(1'b1, `IRQ_STAT_OFF, 32'h1f);
        disk_in <= 1'b0;
        repeat (5) @(posedge pclk);
        apb(1'b0, `IRQ_STAT_OFF, 32'h0);
        `CHK(rd[`EV_CHANGED], 1'b1)
        apb(1'b0, `STAT_OFF, 32'h0);
        `CHK(rd[3:0], 4'h2)
        // reinsert: the change flag holds until a step strobe follows
        disk_in <= 1'b1;
        repeat (4) @(posedge pclk);
        `CHK(media_changed_n, 1'b0)
        cmd(32'h1);
        `CHK(rd[1:0], 2'h1)
        close_out();
    end
    // a stuck handshake must not hang the run
    initial begin
        #200000;
        n_mismatch++;
        close_out();
    end
endmodule
